// File: pcm_meter_caps.sv
// Pixel clock meter and peer capability register bank
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Any nonzero write to the meter register starts a gated pixel edge count.
// - Gate lasts the written byte times one oscillator period (40 ns).
// - Reading the meter register returns edges counted in the last gate.
// - Edge count saturates and holds at 0xFF, never wrapping.
// - While capability lock is set, no auto-load of peer fields happens.
// - With lock set, capability fields keep the values software wrote.
// - Bit 5 set makes the serializer send the frequency training pattern.
// - Bit 4 set makes the serializer send the equalization training pattern.
// - Bit 3 tells whether the far-end receiver supports two lanes.
// - Bit 2 gives channel role: zero primary channel 0, one secondary 1.
// - On receive lock with lock bit clear, peer values load bits 5 to 2.
module pcm_meter_caps (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic pixel_clk_in,
  input wire logic rx_lock_in,
  input wire logic [3:0] peer_caps,
  output logic request_freq_training,
  output logic request_equalizer_training,
  output logic peer_two_lane_capable,
  output logic peer_channel_secondary,
  output logic meter_busy
);
  import pcm_pkg::*;

  typedef struct packed {
    logic pix_s1;
    logic pix_s2;
    logic pix_s3;
    logic pix_lvl;
    logic lock_s1;
    logic lock_s2;
    logic lock_s3;
    logic lock_lvl;
    logic gate;
    logic [2:0] presc;
    logic [7:0] ticks;
    logic [7:0] count;
    logic [7:0] caps;
    logic [7:0] rdata;
  } pcm_state_t;

  pcm_state_t st_q, st_d;
  logic wr_meter, wr_caps, rd_meter, rd_caps, pix_rise, lock_rise;

  assign wr_meter = reg_wr && (reg_addr == PCM_ADDR_METER);
  assign wr_caps = reg_wr && (reg_addr == PCM_ADDR_CAPS);
  assign rd_meter = reg_rd && (reg_addr == PCM_ADDR_METER);
  assign rd_caps = reg_rd && (reg_addr == PCM_ADDR_CAPS);

  // -----------------------------------------------------------
  // Next state
  // -----------------------------------------------------------
  always_comb begin
    st_d = st_q;
    pix_rise = 1'b0;
    lock_rise = 1'b0;
    // Pixel clock and lock are foreign: a change counts once stages two and three agree
    st_d.pix_s1 = pixel_clk_in;
    st_d.pix_s2 = st_q.pix_s1;
    st_d.pix_s3 = st_q.pix_s2;
    if (st_q.pix_s2 == st_q.pix_s3) begin
      st_d.pix_lvl = st_q.pix_s3;
      pix_rise = st_q.pix_s3 && !st_q.pix_lvl;
    end
    st_d.lock_s1 = rx_lock_in;
    st_d.lock_s2 = st_q.lock_s1;
    st_d.lock_s3 = st_q.lock_s2;
    if (st_q.lock_s2 == st_q.lock_s3) begin
      st_d.lock_lvl = st_q.lock_s3;
      lock_rise = st_q.lock_s3 && !st_q.lock_lvl;
    end

    // Limitation: pixel clock must stay well below a quarter of ref_clk to be counted
    if (wr_meter) begin
      st_d.gate = (reg_wdata != PCM_ZERO);
      st_d.ticks = reg_wdata;
      st_d.presc = PCM_PRESC_RESET;
      st_d.count = PCM_METER_RESET;
    end else if (st_q.gate) begin
      if (pix_rise && (st_q.count != PCM_COUNT_MAX)) begin
        st_d.count = st_q.count + 8'h01;
      end
      if (st_q.presc == PCM_PRESC_LAST) begin
        st_d.presc = PCM_PRESC_RESET;
        st_d.ticks = st_q.ticks - 8'h01;
        if (st_q.ticks == 8'h01) begin
          st_d.gate = 1'b0;
        end
      end else begin
        st_d.presc = st_q.presc + 3'h1;
      end
    end

    // Software write wins over an auto-load in the same cycle
    if (wr_caps) begin
      st_d.caps = reg_wdata;
      st_d.caps[PCM_BIT_RSVD] = 1'b0;
    end else if (lock_rise && !st_q.caps[PCM_BIT_LOCK]) begin
      st_d.caps[PCM_BIT_CHAN +: 4] = peer_caps;
    end

    if (rd_meter) begin
      st_d.rdata = st_q.count;
    end else if (rd_caps) begin
      st_d.rdata = st_q.caps;
    end else if (reg_rd) begin
      st_d.rdata = PCM_ZERO;
    end
  end

  // -----------------------------------------------------------
  // State register
  // -----------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.count <= PCM_METER_RESET;
      st_q.caps <= PCM_CAPS_RESET;
      st_q.presc <= PCM_PRESC_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign request_freq_training = st_q.caps[PCM_BIT_FREQ];
  assign request_equalizer_training = st_q.caps[PCM_BIT_EQ];
  assign peer_two_lane_capable = st_q.caps[PCM_BIT_DUAL];
  assign peer_channel_secondary = st_q.caps[PCM_BIT_CHAN];
  assign meter_busy = st_q.gate;

  // -----------------------------------------------------------
  // Checks
  // -----------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic [15:0] chk_cnt_q;
  logic [7:0] chk_len_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      chk_cnt_q <= 16'h0000;
      chk_len_q <= 8'h00;
    end else if (wr_meter) begin
      chk_cnt_q <= 16'h0000;
      chk_len_q <= reg_wdata;
    end else if (st_q.gate) begin
      chk_cnt_q <= chk_cnt_q + 16'h0001;
    end
  end

  a_write_starts_gate: assert property (
    (wr_meter && reg_wdata != PCM_ZERO) |=> st_q.gate && st_q.count == PCM_ZERO)
    else $error("Meter write did not open the gate");
  a_gate_length: assert property (
    $fell(st_q.gate) && !$past(wr_meter) |->
      chk_cnt_q == 16'(chk_len_q) * 16'(PCM_OSC_CYC))
    else $error("Gate length differs from written value times oscillator period");
  a_read_returns_count: assert property (
    rd_meter |=> reg_rdata == $past(st_q.count))
    else $error("Meter read did not return the edge count");
  a_count_saturates: assert property (
    (st_q.count == PCM_COUNT_MAX && !wr_meter) |=> st_q.count == PCM_COUNT_MAX)
    else $error("Edge count left its saturated value");
  a_count_frozen_idle: assert property (
    (!st_q.gate && !wr_meter) |=> $stable(st_q.count))
    else $error("Edge count changed outside the gate");
  a_lock_blocks_load: assert property (
    (st_q.caps[PCM_BIT_LOCK] && !wr_caps) |=> $stable(st_q.caps))
    else $error("Capabilities changed while locked");
  a_locked_keeps_write: assert property (
    (wr_caps && reg_wdata[PCM_BIT_LOCK]) ##1 (!wr_caps)[*3] |->
      st_q.caps[5:2] == $past(reg_wdata[5:2], 3))
    else $error("Locked capability fields lost the written value");
  a_autoload_on_lock: assert property (
    (lock_rise && !st_q.caps[PCM_BIT_LOCK] && !wr_caps) |=>
      st_q.caps[5:2] == $past(peer_caps))
    else $error("Peer capabilities not loaded on receive lock");
  a_reserved_bit_zero: assert property (
    rd_caps |=> !reg_rdata[PCM_BIT_RSVD])
    else $error("Reserved capability bit read as one");
  a_training_outputs: assert property (
    wr_caps |=> request_freq_training == $past(reg_wdata[PCM_BIT_FREQ])
      && request_equalizer_training == $past(reg_wdata[PCM_BIT_EQ]))
    else $error("Training requests do not follow the written bits");
  // Read-back and pin views of the stored capability bits
  a_caps_read_back: assert property (
    rd_caps |=> reg_rdata == $past(st_q.caps))
    else $error("Capability read did not return the stored value");
  a_two_lane_output: assert property (
    wr_caps |=> peer_two_lane_capable == $past(reg_wdata[PCM_BIT_DUAL]))
    else $error("Two-lane capability output does not follow the written bit");
  a_channel_role_output: assert property (
    wr_caps |=> peer_channel_secondary == $past(reg_wdata[PCM_BIT_CHAN]))
    else $error("Channel role output does not follow the written bit");
  // Auto-load is an event on lock rise, never a copy that follows the peer level
  a_no_idle_load: assert property (
    (!lock_rise && !wr_caps) |=> $stable(st_q.caps))
    else $error("Capabilities changed without a write or a lock rise");
  // Meter start and counting bounds
  a_gate_needs_write: assert property (
    $rose(st_q.gate) |-> $past(wr_meter))
    else $error("Gate opened without a meter write");
  a_zero_write_idle: assert property (
    (wr_meter && reg_wdata == PCM_ZERO) |=> !st_q.gate && st_q.count == PCM_ZERO)
    else $error("Zero-length meter write left the gate or count set");
  a_count_no_wrap: assert property (
    (st_q.gate && !wr_meter) |=> st_q.count >= $past(st_q.count))
    else $error("Edge count decreased while the gate was open");
endmodule

`default_nettype wire

// File: pcm_meter_caps_tb_top.sv
// Self-checking bench for the pixel clock meter and peer capability bank
`timescale 1ns/1ps
`default_nettype none
module pcm_meter_caps_tb_top;
  import pcm_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] pix_half = 8'h00;
  logic lock_req = 1'b0;
  logic [3:0] caps_req = 4'h0;
  logic [7:0] reg_rdata;
  logic pixel_clk, rx_lock, meter_busy;
  logic [3:0] peer_caps;
  wire logic [3:0] caps_out;
  int n_fail = 0;
  int checked = 0;
  pcm_peer_model peer (.pix_half(pix_half), .lock_req(lock_req), .caps_req(caps_req),
    .pixel_clk(pixel_clk), .rx_lock(rx_lock), .peer_caps(peer_caps));
  pcm_meter_caps dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pixel_clk_in(pixel_clk), .rx_lock_in(rx_lock), .peer_caps(peer_caps),
    .request_freq_training(caps_out[3]), .request_equalizer_training(caps_out[2]),
    .peer_two_lane_capable(caps_out[1]), .peer_channel_secondary(caps_out[0]),
    .meter_busy(meter_busy));
  initial forever #4 ref_clk = ~ref_clk;
  // ----------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------
  task automatic finish_test();
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    checked++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
      n_fail++;
      $display("mismatch at %0t: got %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    reg_rd = 1'b0;
    tick();
    d = reg_rdata;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    cmp8(d, exp);
  endtask
  // Gate length is checked from the busy flag, the count by reading back
  task automatic measure(input logic [7:0] n, input logic [7:0] half, input logic [15:0] lo,
    input logic [15:0] hi);
    int cyc;
    logic [7:0] d;
    pix_half = half;
    wr(PCM_ADDR_METER, n);
    cyc = 0;
    while (meter_busy !== 1'b0 && cyc < 3000) begin
      tick();
      cyc++;
    end
    if (cyc >= 3000) begin
      n_fail++;
      finish_test();
    end
    // Busy is seen low exactly n oscillator periods of reference clock edges after the write edge
    if (n != 8'h00) cmp_rng(16'(cyc + 1), 16'(n * PCM_OSC_CYC_I), 16'(n * PCM_OSC_CYC_I));
    rd_reg(PCM_ADDR_METER, d);
    cmp_rng({8'h00, d}, lo, hi);
  endtask
  task automatic lock_pulse(input logic [3:0] v);
    caps_req = v;
    lock_req = 1'b1;
    repeat (8) tick();
    lock_req = 1'b0;
    repeat (8) tick();
  endtask
  task automatic caps_check(input logic [7:0] exp);
    chk_rd(PCM_ADDR_CAPS, exp);
    cmp8({4'h0, caps_out}, {4'h0, exp[5:2]});
  endtask
  initial begin
    repeat (16) tick();
    srst = 1'b0;
    chk_rd(PCM_ADDR_METER, PCM_METER_RESET);
    chk_rd(PCM_ADDR_CAPS, PCM_CAPS_RESET);
    wr(8'h21, 8'hFF);
    chk_rd(8'h21, 8'h00);
    measure(8'd10, 8'd40, 16'd4, 16'd6);
    measure(8'd255, 8'd18, 16'd255, 16'd255);
    measure(8'd4, 8'd40, 16'd1, 16'd3);
    measure(8'd0, 8'd40, 16'd0, 16'd0);
    wr(PCM_ADDR_CAPS, 8'hFF);
    caps_check(8'hBF);
    lock_pulse(4'h0);
    caps_check(8'hBF);
    wr(PCM_ADDR_CAPS, 8'h00);
    lock_pulse(4'hA);
    caps_check(8'h28);
    lock_pulse(4'h5);
    caps_check(8'h14);
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire

// File: pcm_peer_model.sv
// Far-end receiver stand-in: pixel source, receive lock and capability values
`timescale 1ns/1ps
`default_nettype none
module pcm_peer_model (
  input wire logic [7:0] pix_half,
  input wire logic lock_req,
  input wire logic [3:0] caps_req,
  output logic pixel_clk,
  output logic rx_lock,
  output logic [3:0] peer_caps
);
  // Stands low while stopped so no stray edge is counted
  always begin
    if (pix_half != 8'h00) begin
      #(pix_half) pixel_clk = ~pixel_clk;
    end else begin
      pixel_clk = 1'b0;
      #8;
    end
  end
  assign rx_lock = lock_req;
  // Values mean nothing while unlocked, so show their inverse then
  assign peer_caps = lock_req ? caps_req : ~caps_req;
endmodule
`default_nettype wire

// File: pcm_pkg.sv
// Constants for the pixel clock meter and peer capability register bank
package pcm_pkg;
  localparam logic [7:0] PCM_ADDR_METER = 8'h1F;
  localparam logic [7:0] PCM_ADDR_CAPS = 8'h20;
  localparam logic [7:0] PCM_METER_RESET = 8'h00;
  localparam logic [7:0] PCM_CAPS_RESET = 8'h00;
  localparam logic [7:0] PCM_COUNT_MAX = 8'hFF;
  localparam logic [7:0] PCM_ZERO = 8'h00;
  // Bit positions in the capabilities register
  localparam int PCM_BIT_LOCK = 7;
  localparam int PCM_BIT_RSVD = 6;
  localparam int PCM_BIT_FREQ = 5;
  localparam int PCM_BIT_EQ = 4;
  localparam int PCM_BIT_DUAL = 3;
  localparam int PCM_BIT_CHAN = 2;
  // Gate timing: one oscillator period expressed in reference clock cycles
  localparam int PCM_OSC_PERIOD_NS = 40;
  localparam int PCM_CLK_PERIOD_NS = 8;
  localparam int PCM_OSC_CYC_I = (PCM_OSC_PERIOD_NS + PCM_CLK_PERIOD_NS - 1) / PCM_CLK_PERIOD_NS;
  localparam logic [2:0] PCM_OSC_CYC = 3'(PCM_OSC_CYC_I);
  localparam logic [2:0] PCM_PRESC_RESET = 3'h0;
  localparam logic [2:0] PCM_PRESC_LAST = 3'(PCM_OSC_CYC_I - 1);
endpackage
